//--- inc/pwm_sync_defines.svh
// Constants for the three-unit period synchronization control block.
// Assumes byte-wide control registers at consecutive indices.
`ifndef PWM_SYNC_DEFINES_SVH
`define PWM_SYNC_DEFINES_SVH

`define SYNC_REG_W 8
`define SYNC_ADDR_W 2
`define UNIT1_SYNC_OFS 2'h0
`define UNIT2_SYNC_OFS 2'h1
`define UNIT3_SYNC_OFS 2'h2
`define PHASE_OFFSET_BIT 7
`define PERIOD_INV_BIT 6
`define DUTY_INV_BIT 5
`define SYNC_MODE_LSB 0
`define SYNC_IMPL_MASK 8'hE3
`define SYNC_RESET_VAL 8'h00
`define UNMAPPED_READ_VAL 8'h00

`endif

//--- inc/pwm_sync_pkg.sv
// Types shared by the synchronization control block and its register file.
// Assumes the constants header is included by the users where needed.
package pwm_sync_pkg;

  // Code n selects unit n as the sync source; 2'b00 selects none
  typedef enum logic [1:0] {
    SRC_NONE  = 2'b00,
    SRC_UNIT1 = 2'b01,
    SRC_UNIT2 = 2'b10,
    SRC_UNIT3 = 2'b11
  } sync_src_t;

  typedef struct packed {
    logic phase_offset_sel;
    logic period_input_invert;
    logic duty_input_invert;
    logic [2:0] unused;
    sync_src_t sync_source_sel;
  } sync_ctrl_t;

  typedef struct packed {
    sync_ctrl_t unit3;
    sync_ctrl_t unit2;
    sync_ctrl_t unit1;
  } sync_regs_t;

  typedef struct packed {
    logic [2:0] period_lvl;
    logic [2:0] duty_lvl;
    logic [2:0] period_evt;
    logic [2:0] duty_evt;
    logic [2:0] sync_out;
    logic [2:0] latch_set;
    logic [7:0] rd_data;
  } core_state_t;

endpackage

//--- inc/sync_cfg_if.sv
// Carrier between the sync control core and its register file.
// Assumes one clock domain; write side is the core, storage side the regs.
`timescale 1ns/100ps
interface sync_cfg_if;
  logic wr;
  logic [1:0] addr;
  logic [7:0] wdata;
  pwm_sync_pkg::sync_regs_t regs;
  modport bus (output wr, output addr, output wdata, input regs);
  modport store (input wr, input addr, input wdata, output regs);
endinterface

//--- core/sync_reg_file.sv
// Storage for the three unit synchronization control registers.
// Assumes writes arrive as one-cycle strobes, synchronous to ref_clk.
`timescale 1ns/100ps
`include "pwm_sync_defines.svh"
module sync_reg_file (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sync_cfg_if.store cfg
);

  pwm_sync_pkg::sync_regs_t regs_q;
  pwm_sync_pkg::sync_regs_t regs_d;

  function automatic logic [7:0] masked(input logic [7:0] v);
    masked = v & `SYNC_IMPL_MASK;
  endfunction

  always_comb begin
    regs_d = regs_q;
    if (cfg.wr) begin
      // RULE15: unimplemented bits dropped
      case (cfg.addr)
        `UNIT1_SYNC_OFS: regs_d.unit1 = masked(cfg.wdata);
        `UNIT2_SYNC_OFS: regs_d.unit2 = masked(cfg.wdata);
        `UNIT3_SYNC_OFS: regs_d.unit3 = masked(cfg.wdata);
        default: regs_d = regs_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    // RULE16: all bits clear on reset
    if (sys_rst) begin
      regs_q <= {3{`SYNC_RESET_VAL}};
    end else begin
      regs_q <= regs_d;
    end
  end

  assign cfg.regs = regs_q;

  // RULE15: reserved bits stay zero
  a_unused_bits_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (regs_q.unit1.unused | regs_q.unit2.unused | regs_q.unit3.unused) == 3'h0)
    else $error("reserved control bits became set"); // RULE15

  // RULE16: write lands next cycle
  a_write_stored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cfg.wr && cfg.addr == `UNIT2_SYNC_OFS |=>
    regs_q.unit2 == ($past(cfg.wdata) & `SYNC_IMPL_MASK))
    else $error("unit2 control write not stored"); // RULE16

endmodule // sync_reg_file

//--- core/pwm_period_sync_control.sv
// Period synchronization control for three PWM units.
// Assumes all event inputs are synchronous to ref_clk.
// Function
// RULE1: offset set: sync from phase, latch from period
// RULE2: offset clear: sync from period, latch from phase
// RULE3: period invert bit inverts period inputs
// RULE4: duty invert bit inverts duty inputs
// RULE5: unit1 mode 11 takes unit3 sync
// RULE6: unit1 mode 10 takes unit2 sync
// RULE7: unit1 mode 00 ignores sibling sync
// RULE8: unit2 mode 11 takes unit3 sync
// RULE9: unit2 mode 01 takes unit1 sync
// RULE10: unit2 mode 00 runs unsynchronized
// RULE11: unit3 mode 10 takes unit2 sync
// RULE12: unit3 mode 01 takes unit1 sync
// RULE13: unit3 mode 00 runs unsynchronized
// RULE14: software never writes self-referencing mode
// RULE15: bits 4..2 read zero, ignore writes
// RULE16: implemented bits read/write, reset to zero
// RULE17: sibling sync pulse restarts local period
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "pwm_sync_defines.svh"
module pwm_period_sync_control (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] period_in,
  input wire logic [2:0] duty_in,
  input wire logic [2:0] phase_pulse,
  output logic [2:0] period_evt,
  output logic [2:0] duty_evt,
  output logic [2:0] sync_out,
  output logic [2:0] latch_set
);

  sync_cfg_if cfg ();
  pwm_sync_pkg::core_state_t q;
  pwm_sync_pkg::core_state_t d;
  pwm_sync_pkg::sync_ctrl_t ctrl [3];

  sync_reg_file regs_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cfg(cfg)
  );

  assign cfg.wr = reg_wr;
  assign cfg.addr = reg_addr;
  assign cfg.wdata = reg_wdata;
  assign ctrl[0] = cfg.regs.unit1;
  assign ctrl[1] = cfg.regs.unit2;
  assign ctrl[2] = cfg.regs.unit3;

  // A mode code naming the unit itself is reserved; it is decoded as
  // unsynchronized so that a unit can never restart itself in a loop.
  function automatic logic sync_hit(
    input pwm_sync_pkg::sync_src_t src,
    input int unsigned self,
    input logic [2:0] outs
  );
    logic hit;
    hit = 1'b0;
    case (src)
      pwm_sync_pkg::SRC_UNIT1: hit = (self != 0) && outs[0];
      pwm_sync_pkg::SRC_UNIT2: hit = (self != 1) && outs[1];
      pwm_sync_pkg::SRC_UNIT3: hit = (self != 2) && outs[2];
      default: hit = 1'b0;
    endcase
    sync_hit = hit;
  endfunction

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  always_comb begin
    logic per_lvl;
    logic dut_lvl;
    logic restart;
    logic per_evt;
    per_lvl = 1'b0;
    dut_lvl = 1'b0;
    restart = 1'b0;
    per_evt = 1'b0;
    d = q;
    for (int unsigned i = 0; i < 3; i++) begin
      // RULE3: period input polarity
      per_lvl = period_in[i] ^ ctrl[i].period_input_invert;
      // RULE4: duty input polarity
      dut_lvl = duty_in[i] ^ ctrl[i].duty_input_invert;
      // RULE5: sibling sync source decode
      // RULE7: mode 00 selects nothing
      // RULE6: unit1 takes unit2
      // RULE8: unit2 takes unit3
      // RULE9: unit2 takes unit1
      // RULE10: unit2 mode 00 idle
      // RULE11: unit3 takes unit2
      // RULE12: unit3 takes unit1
      // RULE13: unit3 mode 00 idle
      restart = sync_hit(ctrl[i].sync_source_sel, i, q.sync_out);
      // RULE17: sibling sync restarts period
      per_evt = rise(per_lvl, q.period_lvl[i]) | restart;
      d.period_lvl[i] = per_lvl;
      d.duty_lvl[i] = dut_lvl;
      d.period_evt[i] = per_evt;
      d.duty_evt[i] = rise(dut_lvl, q.duty_lvl[i]);
      // RULE1: offset mode swaps sources
      // RULE2: default sources
      if (ctrl[i].phase_offset_sel) begin
        d.sync_out[i] = phase_pulse[i];
        d.latch_set[i] = per_evt;
      end else begin
        d.sync_out[i] = per_evt;
        d.latch_set[i] = phase_pulse[i];
      end
    end
    // RULE16: registers read back
    d.rd_data = `UNMAPPED_READ_VAL;
    if (reg_rd) begin
      case (reg_addr)
        `UNIT1_SYNC_OFS: d.rd_data = ctrl[0];
        `UNIT2_SYNC_OFS: d.rd_data = ctrl[1];
        `UNIT3_SYNC_OFS: d.rd_data = ctrl[2];
        default: d.rd_data = `UNMAPPED_READ_VAL;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rd_data;
  assign period_evt = q.period_evt;
  assign duty_evt = q.duty_evt;
  assign sync_out = q.sync_out;
  assign latch_set = q.latch_set;

  // Per-unit checks on event routing and polarity
  for (genvar u = 0; u < 3; u++) begin : g_chk
    // RULE1: offset on, phase drives sync
    a_offset_sync_phase: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      ctrl[u].phase_offset_sel |=> sync_out[u] == $past(phase_pulse[u]))
      else $error("sync output not from phase event"); // RULE1

    // RULE1: offset on, period sets latch
    a_offset_latch_per: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      ctrl[u].phase_offset_sel |=> latch_set[u] == period_evt[u])
      else $error("latch set not from period event"); // RULE1

    // RULE2: offset off, period drives sync
    a_plain_sync_per: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      !ctrl[u].phase_offset_sel |=> sync_out[u] == period_evt[u])
      else $error("sync output not from period event"); // RULE2

    // RULE2: offset off, phase sets latch
    a_plain_latch_phase: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      !ctrl[u].phase_offset_sel |=> latch_set[u] == $past(phase_pulse[u]))
      else $error("latch set not from phase event"); // RULE2

    // RULE3: inverted period edge detected
    a_period_inv_edge: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      ctrl[u].period_input_invert && $stable(ctrl[u].period_input_invert)
      && $fell(period_in[u]) |=> period_evt[u])
      else $error("inverted period edge missed"); // RULE3

    // RULE3: plain period edge detected
    a_period_pass_edge: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      !ctrl[u].period_input_invert && $stable(ctrl[u].period_input_invert)
      && $rose(period_in[u]) |=> period_evt[u])
      else $error("period rising edge missed"); // RULE3

    // RULE4: duty event follows polarity
    a_duty_polarity: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      $stable(ctrl[u].duty_input_invert) && (ctrl[u].duty_input_invert ?
      $fell(duty_in[u]) : $rose(duty_in[u])) |=> duty_evt[u])
      else $error("duty edge not detected"); // RULE4

    // RULE4: no duty event without edge
    a_duty_no_spur: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      $stable(duty_in[u]) && $stable(ctrl[u].duty_input_invert)
      |=> !duty_evt[u])
      else $error("duty event without input edge"); // RULE4
  end

  // RULE5: unit1 follows unit3
  a_u1_from_u3: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[0].sync_source_sel == pwm_sync_pkg::SRC_UNIT3 && sync_out[2]
    |=> period_evt[0])
    else $error("unit1 missed unit3 sync"); // RULE5

  // RULE6: unit1 follows unit2
  a_u1_from_u2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[0].sync_source_sel == pwm_sync_pkg::SRC_UNIT2 && sync_out[1]
    |=> period_evt[0])
    else $error("unit1 missed unit2 sync"); // RULE6

  // RULE7: unit1 free running
  a_u1_free: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[0].sync_source_sel == pwm_sync_pkg::SRC_NONE
    && !$rose(period_in[0] ^ ctrl[0].period_input_invert)
    && $stable(ctrl[0].period_input_invert) |=> !period_evt[0])
    else $error("unit1 restarted while unsynchronized"); // RULE7

  // RULE8: unit2 follows unit3
  a_u2_from_u3: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[1].sync_source_sel == pwm_sync_pkg::SRC_UNIT3 && sync_out[2]
    |=> period_evt[1])
    else $error("unit2 missed unit3 sync"); // RULE8

  // RULE9: unit2 follows unit1
  a_u2_from_u1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[1].sync_source_sel == pwm_sync_pkg::SRC_UNIT1 && sync_out[0]
    |=> period_evt[1])
    else $error("unit2 missed unit1 sync"); // RULE9

  // RULE10: unit2 free running
  a_u2_free: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[1].sync_source_sel == pwm_sync_pkg::SRC_NONE
    && !$rose(period_in[1] ^ ctrl[1].period_input_invert)
    && $stable(ctrl[1].period_input_invert) |=> !period_evt[1])
    else $error("unit2 restarted while unsynchronized"); // RULE10

  // RULE11: unit3 follows unit2
  a_u3_from_u2: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[2].sync_source_sel == pwm_sync_pkg::SRC_UNIT2 && sync_out[1]
    |=> period_evt[2])
    else $error("unit3 missed unit2 sync"); // RULE11

  // RULE12: unit3 follows unit1
  a_u3_from_u1: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[2].sync_source_sel == pwm_sync_pkg::SRC_UNIT1 && sync_out[0]
    |=> period_evt[2])
    else $error("unit3 missed unit1 sync"); // RULE12

  // RULE13: unit3 free running
  a_u3_free: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl[2].sync_source_sel == pwm_sync_pkg::SRC_NONE
    && !$rose(period_in[2] ^ ctrl[2].period_input_invert)
    && $stable(ctrl[2].period_input_invert) |=> !period_evt[2])
    else $error("unit3 restarted while unsynchronized"); // RULE13

  // RULE14: reserved self code has no effect
  a_self_code_inert: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    ctrl[0].sync_source_sel == pwm_sync_pkg::SRC_UNIT1
    && !$rose(period_in[0] ^ ctrl[0].period_input_invert)
    && $stable(ctrl[0].period_input_invert) |=> !period_evt[0])
    else $error("unit1 reacted to its own sync"); // RULE14

  // RULE15: reserved bits read zero
  a_read_rsvd_zero: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    reg_rd |=> reg_rdata[4:2] == 3'h0)
    else $error("reserved bits read nonzero"); // RULE15

  // RULE16: write then read returns data
  a_write_readback: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    reg_wr && reg_addr == `UNIT1_SYNC_OFS ##1
    reg_rd && reg_addr == `UNIT1_SYNC_OFS && !reg_wr
    |=> reg_rdata == ($past(reg_wdata, 2) & `SYNC_IMPL_MASK))
    else $error("unit1 control readback mismatch"); // RULE16

  // RULE16: unmapped and idle reads zero
  a_read_idle_zero: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    !reg_rd || reg_addr == 2'h3 |=> reg_rdata == `UNMAPPED_READ_VAL)
    else $error("read data outside read slot"); // RULE16

  // RULE17: unit1 sync restarts unit2 next cycle
  a_restart_one_cycle: assert property (@(posedge ref_clk)
    disable iff (sys_rst)
    ctrl[1].sync_source_sel == pwm_sync_pkg::SRC_UNIT1
    && $stable(ctrl[1]) && !ctrl[0].phase_offset_sel
    && $rose(sync_out[0]) |=> period_evt[1])
    else $error("sibling sync did not restart unit2"); // RULE17

  // RULE16: reset clears outputs and controls
  a_reset_clears: assert property (@(posedge ref_clk) // RULE16
    $fell(sys_rst) |-> {reg_rdata, period_evt, duty_evt, sync_out,
    latch_set} == 20'h00000 && cfg.regs == 24'h000000)
    else $error("outputs or controls not clear after reset");

  // RULE16: unit3 write lands next cycle
  a_unit3_stored: assert property (@(posedge ref_clk) // RULE16
    disable iff (sys_rst)
    reg_wr && reg_addr == `UNIT3_SYNC_OFS
    |=> ctrl[2] == ($past(reg_wdata) & `SYNC_IMPL_MASK))
    else $error("unit3 control write not stored");

endmodule // pwm_period_sync_control

//--- test/pwm_sibling_model.sv
// Sibling PWM units as seen by the sync block: sources of period, duty
// and phase events. Assumes fire requests are one-cycle strobes on ref_clk.
`timescale 1ns/100ps
module pwm_sibling_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] fire_per,
  input wire logic [2:0] fire_duty,
  input wire logic [2:0] fire_phase,
  output logic [2:0] period_in = 3'h0,
  output logic [2:0] duty_in = 3'h0,
  output logic [2:0] phase_pulse = 3'h0
);
  // One-cycle high level: each fire gives one rise and one fall, so an
  // inverted input sees its event one cycle later than a plain one
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      period_in <= 3'h0;
      duty_in <= 3'h0;
      phase_pulse <= 3'h0;
    end else begin
      period_in <= fire_per;
      duty_in <= fire_duty;
      phase_pulse <= fire_phase;
    end
  end
endmodule // pwm_sibling_model

//--- test/tb.sv
// Self-checking bench for the three-unit period sync control block.
// Assumes the sibling model drives the event inputs; bus driven here.
`timescale 1ns/100ps
`include "pwm_sync_defines.svh"
module tb;
  typedef struct packed {
    logic [7:0] c1, c2, c3;
    logic [2:0] p, d, ph;
    logic [11:0] e0, e1;
  } row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rv;
  logic [2:0] period_in, duty_in, phase_pulse;
  logic [2:0] period_evt, duty_evt, sync_out, latch_set;
  logic [2:0] fp = 3'h0, fd = 3'h0, fh = 3'h0;
  logic [11:0] snap;
  logic [7:0] wd [0:3];
  int mismatches = 0;
  int check_count = 0;
  row_t rows [0:11];
  assign snap = {period_evt, duty_evt, sync_out, latch_set};

  pwm_period_sync_control dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_in(period_in),
    .duty_in(duty_in), .phase_pulse(phase_pulse),
    .period_evt(period_evt), .duty_evt(duty_evt), .sync_out(sync_out),
    .latch_set(latch_set));
  pwm_sibling_model sib (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .fire_per(fp), .fire_duty(fd), .fire_phase(fh),
    .period_in(period_in), .duty_in(duty_in), .phase_pulse(phase_pulse));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobe stays up across back-to-back writes; the next access drops it
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [1:0] a);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic ev(input row_t r);
    fp <= r.p;
    fd <= r.d;
    fh <= r.ph;
    @(posedge ref_clk);
    fp <= 3'h0;
    fd <= 3'h0;
    fh <= 3'h0;
    @(posedge ref_clk);
    #1 chk(snap, r.e0, "events first");
    @(posedge ref_clk);
    #1 chk(snap, r.e1, "events second");
    @(posedge ref_clk);
    #1 chk(snap, 12'h000, "events third");
    @(posedge ref_clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #50000;
    mismatches++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    // no self-referencing codes in any row
    rows = '{
      '{8'h00, 8'h00, 8'h00, 3'h7, 3'h0, 3'h0, 12'hE38, 12'h000},
      '{8'h00, 8'h01, 8'h01, 3'h1, 3'h0, 3'h0, 12'h208, 12'hC30},
      '{8'h02, 8'h00, 8'h02, 3'h2, 3'h0, 3'h0, 12'h410, 12'hA28},
      '{8'h03, 8'h03, 8'h00, 3'h4, 3'h0, 3'h0, 12'h820, 12'h618},
      '{8'h80, 8'h80, 8'h80, 3'h7, 3'h0, 3'h0, 12'hE07, 12'h000},
      '{8'h80, 8'h80, 8'h80, 3'h0, 3'h0, 3'h7, 12'h038, 12'h000},
      '{8'h00, 8'h00, 8'h00, 3'h0, 3'h0, 3'h7, 12'h007, 12'h000},
      '{8'h00, 8'h00, 8'h00, 3'h0, 3'h7, 3'h0, 12'h1C0, 12'h000},
      '{8'h20, 8'h20, 8'h20, 3'h0, 3'h7, 3'h0, 12'h000, 12'h1C0},
      '{8'h40, 8'h40, 8'h40, 3'h7, 3'h0, 3'h0, 12'h000, 12'hE38},
      '{8'h80, 8'h01, 8'h00, 3'h0, 3'h0, 3'h1, 12'h008, 12'h410},
      '{8'h00, 8'h81, 8'h00, 3'h1, 3'h0, 3'h0, 12'h208, 12'h402}
    };
    wd = '{8'hFF, 8'hFF, 8'hFE, 8'hFF};
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      wr(2'h0, rows[i].c1);
      wr(2'h1, rows[i].c2);
      wr(2'h2, rows[i].c3);
      reg_wr <= 1'b0;
      // Let events from changed invert bits die out first
      repeat (4) @(posedge ref_clk);
      ev(rows[i]);
      $display("row %0d done", i);
    end
    for (int a = 0; a < 4; a++) begin
      wr(a[1:0], wd[a]);
      rd(a[1:0]);
      chk(rv, (a == 3) ? 8'h00 : (wd[a] & `SYNC_IMPL_MASK), "readback");
    end
    #1 chk(reg_rdata, 8'h00, "rdata after");
    @(posedge ref_clk);
    wr(2'h0, 8'h1C);
    rd(2'h0);
    chk(rv, 8'h00, "unused bits");
    $display("register test done");
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 3; a++) begin
      rd(a[1:0]);
      chk(rv, `SYNC_RESET_VAL, "after reset");
    end
    $display("reset test done");
    test_done();
  end
endmodule // tb
